/* File: core/phy_loopback_bypass_error_ctrl.sv */
// loopback, bypass and receive error mask register with its link logic
`timescale 1ns/1ns
`include "pbe_consts.svh"

module pbe_fifo #(
  parameter int WIDTH = `PBE_FIFO_WIDTH,
  parameter int DEPTH = `PBE_FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_q <= cnt_q - (AW+1)'(1);
    end
  end
endmodule : pbe_fifo

module phy_loopback_bypass_error_ctrl
  import pbe_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_clk_link,
  input  wire logic [4:0]  i_mgmt_addr,
  input  wire logic        i_mgmt_wr,
  input  wire logic [15:0] i_mgmt_wdata,
  output logic      [15:0] o_mgmt_rdata,
  input  wire logic        i_legacy_compat,
  input  wire logic        i_pmd_loopback_req,
  input  wire logic        i_coder_bypass_strap_pin,
  input  wire logic        i_alignment_bypass_strap_pin,
  input  wire line_rx_s    i_line_rx,
  input  wire logic        i_mii_tx_en,
  input  wire logic [3:0]  i_mii_txd,
  output logic             o_mii_tx_ready,
  input  wire logic        i_full_duplex,
  input  wire logic        i_speed_100,
  input  wire logic        i_line_tx_ready,
  output logic             o_line_tx_valid,
  output logic      [4:0]  o_line_tx_data,
  output mii_rx_s          o_mii_rx,
  output logic             o_mii_crs,
  output link_cfg_s        o_link_cfg
);
  localparam int CFG_W = $bits(link_cfg_s);

  // ---------------- system clock side ----------------
  logic [1:0]  strap_s1_q;
  logic [1:0]  strap_s2_q;
  logic [1:0]  strap_s3_q;
  logic [1:0]  strap_q;
  logic [15:0] reg_q;
  logic [15:0] strap_word;
  logic [15:0] read_word;
  logic [15:0] rdata_q;
  link_cfg_s   cfg_d;
  link_cfg_s   cfg_sys_q;

  // straps are asynchronous pins: three stages, accept when two agree
  always_ff @(posedge i_clk_sys) begin
    strap_s1_q <= {i_coder_bypass_strap_pin, i_alignment_bypass_strap_pin};
    strap_s2_q <= strap_s1_q;
    strap_s3_q <= strap_s2_q;
  end

  // no reset here: the reset load of the register must see the pin
  // level, and a cleared filter would hide the strap until release
  always_ff @(posedge i_clk_sys) begin
    if (strap_s2_q == strap_s3_q) begin
      strap_q <= strap_s3_q;
    end
  end

  always_comb begin
    strap_word = '0;
    strap_word[`PBE_BIT_CODER_BP] = strap_q[1];
    strap_word[`PBE_BIT_ALIGN_BP] = strap_q[0];
  end

  // the strap level keeps loading while reset is held, so the value
  // that stands at release is the settled pin level
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      reg_q <= `PBE_RESET_VALUE | strap_word;
    end else if (i_mgmt_wr && i_mgmt_addr == `PBE_REG_ADDR) begin
      if (i_legacy_compat) begin
        reg_q <= (i_mgmt_wdata & ~`PBE_LEGACY_LOCK)
                 | (reg_q & `PBE_LEGACY_LOCK);
      end else begin
        reg_q <= i_mgmt_wdata;
      end
    end
  end

  always_comb begin
    cfg_d = '0;
    cfg_d.false_carrier_report_enable = reg_q[`PBE_BIT_FC_REPORT];
    cfg_d.coder_bypass   = reg_q[`PBE_BIT_CODER_BP];
    cfg_d.align_bypass   = reg_q[`PBE_BIT_ALIGN_BP];
    cfg_d.endec_loop     = reg_q[`PBE_BIT_ENDEC_LOOP];
    // conflicting loopback requests cancel each other
    cfg_d.remote_loop    = reg_q[`PBE_BIT_REMOTE_LOOP]
                           & ~i_pmd_loopback_req;
    cfg_d.pmd_loop       = i_pmd_loopback_req
                           & ~reg_q[`PBE_BIT_REMOTE_LOOP];
    cfg_d.preamble_strip = reg_q[`PBE_BIT_STRIP]
                           & ~i_legacy_compat;
    cfg_d.full_duplex_carrier_source_select =
      reg_q[`PBE_BIT_FDX_CRS_SEL];
    cfg_d.loop_tx_suppress = reg_q[`PBE_BIT_LOOP_TX_OFF];
    cfg_d.code_err_select  = reg_q[`PBE_BIT_CERR_SEL];
    cfg_d.code_err_enable  = reg_q[`PBE_BIT_CERR_EN]
                             & ~i_legacy_compat;
  end

  // registered so the crossing starts from a flop, not from gates
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cfg_sys_q <= '0;
    end else begin
      cfg_sys_q <= cfg_d;
    end
  end

  // strip and code error enable read back their effective state
  always_comb begin
    read_word = reg_q;
    read_word[`PBE_BIT_STRIP]   = cfg_d.preamble_strip;
    read_word[`PBE_BIT_CERR_EN] = cfg_d.code_err_enable;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_q <= '0;
    end else if (i_mgmt_addr == `PBE_REG_ADDR) begin
      rdata_q <= read_word;
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_mgmt_rdata = rdata_q;

  // ---------------- link clock side ----------------
  logic             lrst_s1_q;
  logic             lrst_s2_q;
  logic             lrst_s3_q;
  logic [CFG_W-1:0] cfg_s1_q;
  logic [CFG_W-1:0] cfg_s2_q;
  logic [CFG_W-1:0] cfg_s3_q;
  logic [CFG_W-1:0] cfg_lk_q;
  link_cfg_s        cfg;
  logic             link_rst;

  always_ff @(posedge i_clk_link) begin
    lrst_s1_q <= i_srst;
    lrst_s2_q <= lrst_s1_q;
    lrst_s3_q <= lrst_s2_q;
  end

  assign link_rst = lrst_s3_q;

  // quasi-static controls: each bit settles on its own, a mixed word
  // can show for one link cycle while software changes several bits
  always_ff @(posedge i_clk_link) begin
    cfg_s1_q <= cfg_sys_q;
    cfg_s2_q <= cfg_s1_q;
    cfg_s3_q <= cfg_s2_q;
  end

  for (genvar gi = 0; gi < CFG_W; gi++) begin : g_cfg_sync
    always_ff @(posedge i_clk_link) begin
      if (link_rst) begin
        cfg_lk_q[gi] <= 1'b0;
      end else if (cfg_s2_q[gi] == cfg_s3_q[gi]) begin
        cfg_lk_q[gi] <= cfg_s3_q[gi];
      end
    end
  end

  assign cfg        = link_cfg_s'(cfg_lk_q);
  assign o_link_cfg = cfg;

  // transmit path: mii or, in remote loopback, line data into fifo
  logic       local_loop;
  logic       tx_drop;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [4:0] fifo_in_data;
  logic       fifo_out_valid;
  logic [4:0] fifo_out_data;

  assign local_loop = cfg.pmd_loop | cfg.endec_loop;
  assign tx_drop    = local_loop & cfg.loop_tx_suppress;

  always_comb begin
    if (cfg.remote_loop) begin
      fifo_in_valid = i_line_rx.valid & i_line_rx.frame;
      fifo_in_data  = i_line_rx.sym;
    end else begin
      fifo_in_valid = i_mii_tx_en;
      fifo_in_data  = {1'b0, i_mii_txd};
    end
  end

  pbe_fifo #(
    .WIDTH (`PBE_FIFO_WIDTH),
    .DEPTH (`PBE_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk       (i_clk_link),
    .i_rst       (link_rst),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (i_line_tx_ready | tx_drop),
    .o_out_data  (fifo_out_data)
  );

  // mii transmit is ignored, not stalled, during remote loopback
  assign o_mii_tx_ready  = cfg.remote_loop | fifo_in_ready;
  // suppressed loopback data is drained, so the fifo never jams
  assign o_line_tx_valid = fifo_out_valid & ~tx_drop;
  assign o_line_tx_data  = fifo_out_data;

  // receive path toward the mac
  logic [3:0] pre_cnt_q;
  logic       strip_now;
  logic       fc_event;
  mii_rx_s    rx_d;
  mii_rx_s    rx_q;
  logic       rx_carrier;
  logic       crs_q;

  assign strip_now = cfg.preamble_strip & i_speed_100 & ~local_loop
                     & (pre_cnt_q < 4'(`PBE_PRE_NIBBLES));

  always_ff @(posedge i_clk_link) begin
    if (link_rst || !i_line_rx.frame) begin
      pre_cnt_q <= '0;
    end else if (i_line_rx.valid && strip_now) begin
      pre_cnt_q <= pre_cnt_q + 4'(1);
    end
  end

  // no alignment means no false carrier detection; frame still gives carrier
  assign fc_event = i_line_rx.false_carrier & ~i_line_rx.frame
                    & ~cfg.align_bypass;

  always_comb begin
    rx_d = '0;
    if (local_loop) begin
      rx_d.dv = i_mii_tx_en;
      rx_d.d  = {1'b0, i_mii_txd};
    end else if (fc_event) begin
      if (cfg.false_carrier_report_enable) begin
        if (cfg.coder_bypass) begin
          rx_d.d = `PBE_FC_SYMBOL;
        end else begin
          rx_d.er = 1'b1;
          rx_d.d  = {1'b0, `PBE_FC_NIBBLE};
        end
      end
    end else if (i_line_rx.frame && i_line_rx.valid && !strip_now) begin
      rx_d.dv = 1'b1;
      rx_d.d  = cfg.coder_bypass ? i_line_rx.sym
                                 : {1'b0, i_line_rx.sym[3:0]};
      // the enable gates the select entirely
      if (cfg.code_err_enable && i_line_rx.code_error) begin
        rx_d.er = 1'b1;
        rx_d.d  = cfg.code_err_select ? {1'b0, `PBE_CERR_CODE_SET}
                                      : {1'b0, `PBE_CERR_CODE_CLR};
      end
    end
  end

  always_ff @(posedge i_clk_link) begin
    if (link_rst) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  assign o_mii_rx = rx_q;

  assign rx_carrier = i_line_rx.frame | fc_event;

  always_ff @(posedge i_clk_link) begin
    if (link_rst) begin
      crs_q <= 1'b0;
    end else if (i_full_duplex) begin
      crs_q <= cfg.full_duplex_carrier_source_select ? i_mii_tx_en
                                                     : rx_carrier;
    end else begin
      crs_q <= i_mii_tx_en | rx_carrier;
    end
  end

  assign o_mii_crs = crs_q;
endmodule : phy_loopback_bypass_error_ctrl

/* File: core/pbe_consts.svh */
// register map, field positions, reset values and error codes
`ifndef PBE_CONSTS_SVH
`define PBE_CONSTS_SVH

`define PBE_REG_ADDR        5'h18
`define PBE_BIT_FC_REPORT   15
`define PBE_BIT_CODER_BP    14
`define PBE_BIT_ALIGN_BP    12
`define PBE_BIT_ENDEC_LOOP  11
`define PBE_BIT_REMOTE_LOOP 9
`define PBE_BIT_STRIP       7
`define PBE_BIT_FDX_CRS_SEL 6
`define PBE_BIT_LOOP_TX_OFF 5
`define PBE_BIT_CERR_SEL    4
`define PBE_BIT_CERR_EN     0
`define PBE_RESET_VALUE     16'h8020
`define PBE_LEGACY_LOCK     16'h0081
`define PBE_FC_NIBBLE       4'he
`define PBE_FC_SYMBOL       5'h1e
`define PBE_CERR_CODE_SET   4'h5
`define PBE_CERR_CODE_CLR   4'h6
`define PBE_PRE_BYTES       7
`define PBE_PRE_NIBBLES     (`PBE_PRE_BYTES * 2)
`define PBE_FIFO_WIDTH      5
`define PBE_FIFO_DEPTH      8

`endif

/* File: core/pbe_pkg.sv */
// types shared by the loopback, bypass and error mask logic
package pbe_pkg;

  typedef struct packed {
    logic false_carrier_report_enable;
    logic coder_bypass;
    logic align_bypass;
    logic endec_loop;
    logic remote_loop;
    logic pmd_loop;
    logic preamble_strip;
    logic full_duplex_carrier_source_select;
    logic loop_tx_suppress;
    logic code_err_select;
    logic code_err_enable;
  } link_cfg_s;

  typedef struct packed {
    logic       valid;
    logic       frame;
    logic       false_carrier;
    logic       code_error;
    logic [4:0] sym;
  } line_rx_s;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [4:0] d;
  } mii_rx_s;

endpackage : pbe_pkg

/* File: verification/pbe_monitor.sv */
// port checker for the loopback, bypass and error mask block
`timescale 1ns/1ns
module pbe_monitor
  import pbe_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic        i_clk_link,
  input wire logic [4:0]  i_mgmt_addr,
  input wire logic        i_mgmt_wr,
  input wire logic [15:0] i_mgmt_wdata,
  input wire logic [15:0] o_mgmt_rdata,
  input wire logic        i_legacy_compat,
  input wire logic        i_coder_bypass_strap_pin,
  input wire logic        i_alignment_bypass_strap_pin,
  input wire line_rx_s    i_line_rx,
  input wire logic        i_mii_tx_en,
  input wire logic        o_mii_tx_ready,
  input wire logic        i_full_duplex,
  input wire logic        o_line_tx_valid,
  input wire mii_rx_s     o_mii_rx,
  input wire logic        o_mii_crs,
  input wire link_cfg_s   o_link_cfg
);
  link_cfg_s c;
  logic      fc, ce, live;
  assign c    = o_link_cfg;
  assign fc   = i_line_rx.valid && i_line_rx.false_carrier && !i_line_rx.frame;
  assign ce   = i_line_rx.valid && i_line_rx.frame && i_line_rx.code_error;
  // local loopback hides the line, alignment bypass hides false carrier detection
  assign live = !c.endec_loop && !c.pmd_loop && !c.align_bypass;

  property p_reset_value;
    @(posedge i_clk_sys) disable iff (i_srst)
      $fell(i_srst) && i_mgmt_addr == 5'h18 |=> o_mgmt_rdata ==
      {1'b1, i_coder_bypass_strap_pin, 1'b0, i_alignment_bypass_strap_pin,
       12'h020};
  endproperty
  a_reset_value:
    assert property (p_reset_value)
    else $error("reset value wrong");
  property p_readback;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_mgmt_wr && i_mgmt_addr == 5'h18 && !i_legacy_compat) ##1
      (i_mgmt_addr == 5'h18 && !i_mgmt_wr && !i_legacy_compat)
      |=> o_mgmt_rdata == $past(i_mgmt_wdata, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback wrong");
  property p_legacy;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_mgmt_addr == 5'h18 && i_legacy_compat |=> o_mgmt_rdata[7] == 1'b0;
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("strip bit not locked");
  property p_fc;
    @(posedge i_clk_link) disable iff (i_srst)
      fc && c.false_carrier_report_enable && live && !c.coder_bypass
      |=> o_mii_rx.er && !o_mii_rx.dv && o_mii_rx.d[3:0] == 4'he;
  endproperty
  a_fc: assert property (p_fc)
    else $error("false carrier report wrong");
  property p_fc_raw;
    @(posedge i_clk_link) disable iff (i_srst)
      fc && c.false_carrier_report_enable && live && c.coder_bypass
      |=> !o_mii_rx.dv && o_mii_rx.d == 5'h1e;
  endproperty
  a_fc_raw: assert property (p_fc_raw)
    else $error("bypass false carrier wrong");
  property p_fc_none;
    @(posedge i_clk_link) disable iff (i_srst)
      fc && c.align_bypass |=> !o_mii_rx.er;
  endproperty
  a_fc_none: assert property (p_fc_none)
    else $error("false carrier under alignment bypass");
  property p_code_err;
    @(posedge i_clk_link) disable iff (i_srst)
      ce && c.code_err_enable && live && !c.coder_bypass && !c.preamble_strip
      |=> o_mii_rx.dv && o_mii_rx.er
          && o_mii_rx.d[3:0] == (c.code_err_select ? 4'h5 : 4'h6);
  endproperty
  a_code_err: assert property (p_code_err)
    else $error("code error value wrong");
  property p_no_both;
    @(posedge i_clk_link) disable iff (i_srst) !(c.remote_loop && c.pmd_loop);
  endproperty
  a_no_both: assert property (p_no_both)
    else $error("both loopbacks entered");
  property p_remote_rdy;
    @(posedge i_clk_link) disable iff (i_srst) c.remote_loop |-> o_mii_tx_ready;
  endproperty
  a_remote_rdy: assert property (p_remote_rdy)
    else $error("mac transmit not ignored");
  property p_suppress;
    @(posedge i_clk_link) disable iff (i_srst)
      (c.endec_loop || c.pmd_loop) && c.loop_tx_suppress |-> !o_line_tx_valid;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("loopback data reached line");
  property p_crs;
    @(posedge i_clk_link) disable iff (i_srst)
      (i_full_duplex && c.full_duplex_carrier_source_select && !i_mii_tx_en)
      [*2] |=> !o_mii_crs;
  endproperty
  a_crs: assert property (p_crs)
    else $error("carrier sense without transmit");
  c_fc: cover property (@(posedge i_clk_link) fc && live);
  c_code: cover property (@(posedge i_clk_link) ce && c.code_err_enable);
  c_remote: cover property (@(posedge i_clk_link) c.remote_loop && ce == 0);
endmodule : pbe_monitor

/* File: verification/pbe_mac_model.sv */
// behavioural mac: counting nibbles, each held until it is taken
`timescale 1ns/1ns
module pbe_mac_model (
  input  wire logic       i_clk,
  input  wire logic       i_send,
  input  wire logic       i_ready,
  output logic            o_tx_en,
  output logic      [3:0] o_txd
);
  initial begin
    o_tx_en = 1'b0;
    o_txd   = 4'h0;
  end
  always @(posedge i_clk) begin
    if (o_tx_en && i_ready)
      o_txd <= o_txd + 4'h1;
    else if (!o_tx_en)
      o_txd <= i_send ? 4'h0 : ~o_txd;
    // idle data wanders so a stale nibble is never mistaken for a fresh one
    if (!o_tx_en || i_ready)
      o_tx_en <= i_send;
  end
endmodule : pbe_mac_model

/* File: verification/phy_loopback_bypass_error_ctrl_tb_top.sv */
// self-checking bench for the loopback, bypass and error mask block
`timescale 1ns/1ns
module phy_loopback_bypass_error_ctrl_tb_top;
  import pbe_pkg::*;
  logic        clk_sys, srst, clk_link, mgmt_wr, legacy, pmd_req, send, lq;
  logic        tx_en, tx_ready, fdx, spd, ltx_ready, ltx_valid, crs;
  logic [3:0]  txd;
  logic [4:0]  mgmt_addr, ltx_data;
  logic [15:0] mgmt_wdata, mgmt_rdata, w, n;
  line_rx_s    line_rx;
  mii_rx_s     mii_rx;
  link_cfg_s   cfg;
  logic [4:0]  exp_q[$];
  int          num_errors, checked;
  logic [15:0] tc[6] = '{16'h8021, 16'h8031, 16'h8020, 16'hc020, 16'h9020,
                         16'h0020};
  logic [6:0]  te[6] = '{7'h66, 7'h65, 7'h2e, 7'h1e, 7'h00, 7'h00};
  logic [6:0]  tm[6] = '{7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h20, 7'h20};

  phy_loopback_bypass_error_ctrl u_dut (
    .i_clk_sys(clk_sys), .i_srst(srst), .i_clk_link(clk_link),
    .i_mgmt_addr(mgmt_addr), .i_mgmt_wr(mgmt_wr), .i_mgmt_wdata(mgmt_wdata),
    .o_mgmt_rdata(mgmt_rdata), .i_legacy_compat(legacy),
    .i_pmd_loopback_req(pmd_req), .i_coder_bypass_strap_pin(1'b1),
    .i_alignment_bypass_strap_pin(1'b0), .i_line_rx(line_rx),
    .i_mii_tx_en(tx_en), .i_mii_txd(txd), .o_mii_tx_ready(tx_ready),
    .i_full_duplex(fdx), .i_speed_100(spd), .i_line_tx_ready(ltx_ready),
    .o_line_tx_valid(ltx_valid), .o_line_tx_data(ltx_data),
    .o_mii_rx(mii_rx), .o_mii_crs(crs), .o_link_cfg(cfg));
  pbe_mac_model u_mac (.i_clk(clk_link), .i_send(send), .i_ready(tx_ready),
                       .o_tx_en(tx_en), .o_txd(txd));

  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 0;
    #7;
    forever #16 clk_link = ~clk_link;
  end

  // one width for all compares, so registers and link words share it
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(negedge clk_sys);
    mgmt_addr  = a;
    mgmt_wr    = 1;
    mgmt_wdata = d;
    @(negedge clk_sys);
    mgmt_wr   = 0;
    mgmt_addr = 5'h18;
    // settings need a few link cycles to cross over
    repeat (12) @(negedge clk_link);
  endtask : wr
  task automatic rd(logic [4:0] a, logic [15:0] e);
    @(negedge clk_sys);
    mgmt_addr = a;
    @(negedge clk_sys);
    check(mgmt_rdata, e);
  endtask : rd
  task automatic rx(logic [8:0] v, logic [6:0] e, logic [6:0] m);
    @(negedge clk_link);
    line_rx = v;
    @(negedge clk_link);
    check(16'(mii_rx & m), 16'(e));
    line_rx = {4'h0, 5'($urandom)};
  endtask : rx
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge clk_link) begin
    if (tx_en && tx_ready && !lq)
      exp_q.push_back({1'b0, txd});
    if (ltx_valid && ltx_ready)
      check(16'(ltx_data), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hdead);
  end

  initial begin
    void'($urandom(32'he15a));
    {mgmt_wr, legacy, pmd_req, send, lq, fdx, spd, ltx_ready} = '0;
    {srst, mgmt_addr, mgmt_wdata, line_rx} = {1'b1, 5'h18, 16'h0, 9'h0};
    repeat (12) @(negedge clk_sys);
    srst = 0;
    rd(5'h18, 16'hc020);
    wr(5'h17, 16'hffff);
    rd(5'h17, 16'h0000);
    rd(5'h18, 16'hc020);
    repeat (4) begin
      w = 16'($urandom) & 16'hd5ff;
      wr(5'h18, w);
      rd(5'h18, w);
    end
    for (int i = 0; i < 6; i++) begin
      wr(5'h18, tc[i]);
      rx(i<2?9'h1a0:9'h140,te[i],tm[i]);
    end
    spd = 1;
    wr(5'h18, 16'h80a0);
    n = 0;
    for (int i = 0; i < 18; i++) begin
      @(negedge clk_link);
      n = n + mii_rx.dv;
      line_rx = i < 16 ? {4'hc, i == 15 ? 5'h0d : 5'h05} : 9'h0;
    end
    check(n, 16'h2);
    @(negedge clk_sys);
    legacy = 1;
    rd(5'h18, 16'h8020);
    wr(5'h18, 16'h8021);
    @(negedge clk_sys);
    legacy = 0;
    rd(5'h18, 16'h80a0);
    @(negedge clk_link);
    send = 1;
    repeat (20) @(negedge clk_link);
    check(16'(tx_ready), 16'h0);
    send = 0;
    repeat (60) begin
      @(negedge clk_link);
      ltx_ready = 1'($urandom);
    end
    check(16'(exp_q.size()), 16'h0);
    ltx_ready = 1;
    lq = 1;
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_sys);
      pmd_req = !k;
      wr(5'h18, k ? 16'h8820 : 16'h8020);
      send = 1;
      repeat (8) @(negedge clk_link);
      send = 0;
      repeat (8) @(negedge clk_link);
    end
    wr(5'h18, 16'h8220);
    send = 1;
    for (int i = 0; i < 4; i++) begin
      line_rx = {4'hc, 5'(i + 3)};
      exp_q.push_back(5'(i + 3));
      @(negedge clk_link);
    end
    line_rx = 9'h0;
    send = 0;
    check(16'(tx_ready), 16'h1);
    @(negedge clk_sys);
    pmd_req = 1;
    repeat (12) @(negedge clk_link);
    check(16'({cfg.remote_loop, cfg.pmd_loop}), 16'h0);
    @(negedge clk_sys);
    pmd_req = 0;
    wr(5'h18, 16'h8060);
    lq = 0;
    fdx = 1;
    repeat (4) @(negedge clk_link);
    check(16'(crs), 16'h0);
    send = 1;
    repeat (4) @(negedge clk_link);
    check(16'(crs), 16'h1);
    send = 0;
    repeat (20) @(negedge clk_link);
    check(16'(exp_q.size()), 16'h0);
    give_verdict;
  end

  initial begin
    #400000;
    num_errors++;
    give_verdict;
  end
endmodule : phy_loopback_bypass_error_ctrl_tb_top

bind phy_loopback_bypass_error_ctrl pbe_monitor u_mon (.*);
